// *** cpu_host_port_data_mux.sv ***
// Host GPIO port with input latches, output register and memory data path selector.
`timescale 1ns/1ps
`include "cpu_port_defs.svh"
module cpu_host_port_data_mux (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] host_ad_in,
  input wire logic host_wr_stb,
  input wire logic host_rd,
  input wire logic [1:0] host_kind,
  output logic [7:0] host_ad_out,
  output logic host_ad_oe,
  input wire logic [7:0] par_data,
  input wire logic par_valid,
  input wire logic [7:0] flash_rd_data,
  input wire logic flash_rd_valid,
  input wire logic [7:0] card_rd_data,
  input wire logic card_rd_valid,
  output logic [7:0] lat_addr,
  output logic [7:0] lat_data,
  output logic [7:0] lat_cmd,
  output logic [1:0] lat_kind,
  output logic lat_stb,
  output logic [7:0] mem_wdata,
  output logic flash_wr,
  output logic card_wr,
  output logic src_parallel,
  output logic dst_card,
  output logic mode_playback
);

  host_sync_if sy ();

  host_pin_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .pins({host_kind, host_rd, host_wr_stb, host_ad_in}),
    .sy(sy.src)
  );

  cpu_port_pkg::port_state_t q;
  cpu_port_pkg::port_state_t d;

  // Picks the byte of the selected memory; used for read data and its valid.
  function automatic logic [8:0] pick_mem(input logic card, input logic [8:0] fl,
                                          input logic [8:0] cd);
    pick_mem = card ? cd : fl;
  endfunction : pick_mem

  logic [8:0] rd_pick;
  logic wr_kind_pulse;
  logic host_data_wr;
  logic play;

  always_comb begin
    d = q;
    play = q.ctrl[`CTL_PLAYBACK_BIT];
    rd_pick = pick_mem(q.ctrl[`CTL_DST_CARD_BIT], {flash_rd_valid, flash_rd_data},
                       {card_rd_valid, card_rd_data});
    wr_kind_pulse = sy.wr_pulse;
    host_data_wr = wr_kind_pulse && (sy.kind == cpu_port_pkg::KIND_DATA);
    if (ce) begin
      d.lat_stb = 1'b0;
      d.flash_wr = 1'b0;
      d.card_wr = 1'b0;
      if (wr_kind_pulse) begin
        d.lat_kind = sy.kind;
        d.lat_stb = (sy.kind != cpu_port_pkg::KIND_CTRL);
        case (sy.kind)
          cpu_port_pkg::KIND_ADDR: d.lat_addr = sy.ad;
          cpu_port_pkg::KIND_DATA: d.lat_data = sy.ad;
          cpu_port_pkg::KIND_CMD: d.lat_cmd = sy.ad;
          cpu_port_pkg::KIND_CTRL: d.ctrl = sy.ad;
          default: d.lat_stb = 1'b0;
        endcase
      end
      // Writes to memory only happen in download mode; the source bit decides
      // whether the parallel port or host data bytes feed the selector.
      if (!play) begin
        if (q.ctrl[`CTL_SRC_PAR_BIT] && par_valid) begin
          d.mem_wdata = par_data;
          d.flash_wr = !q.ctrl[`CTL_DST_CARD_BIT];
          d.card_wr = q.ctrl[`CTL_DST_CARD_BIT];
        end else if (!q.ctrl[`CTL_SRC_PAR_BIT] && host_data_wr) begin
          d.mem_wdata = sy.ad;
          d.flash_wr = !q.ctrl[`CTL_DST_CARD_BIT];
          d.card_wr = q.ctrl[`CTL_DST_CARD_BIT];
        end
      end else if (rd_pick[8]) begin
        d.out_reg = rd_pick[7:0];
      end
      // The port is driven only while the host holds its read pin, so the
      // host must release its own drivers before raising it.
      d.ad_oe = sy.rd;
      if (sy.rd) begin
        d.ad_out = (sy.kind == cpu_port_pkg::KIND_CTRL) ? q.ctrl : q.out_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{lat_addr: `BYTE_RESET, lat_data: `BYTE_RESET, lat_cmd: `BYTE_RESET,
             lat_kind: cpu_port_pkg::KIND_ADDR, lat_stb: 1'b0,
             ctrl: `CTL_RESET, out_reg: `BYTE_RESET, ad_out: `BYTE_RESET,
             ad_oe: 1'b0, mem_wdata: `BYTE_RESET, flash_wr: 1'b0,
             card_wr: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign host_ad_out = q.ad_out;
  assign host_ad_oe = q.ad_oe;
  assign lat_addr = q.lat_addr;
  assign lat_data = q.lat_data;
  assign lat_cmd = q.lat_cmd;
  assign lat_kind = q.lat_kind;
  assign lat_stb = q.lat_stb;
  assign mem_wdata = q.mem_wdata;
  assign flash_wr = q.flash_wr;
  assign card_wr = q.card_wr;
  assign src_parallel = q.ctrl[`CTL_SRC_PAR_BIT];
  assign dst_card = q.ctrl[`CTL_DST_CARD_BIT];
  assign mode_playback = q.ctrl[`CTL_PLAYBACK_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_host_write(cpu_port_pkg::port_kind_t k);
    ce && sy.wr_pulse && sy.kind == k;
  endsequence

  sequence s_download_par;
    ce && !q.ctrl[`CTL_PLAYBACK_BIT] && q.ctrl[`CTL_SRC_PAR_BIT] && par_valid;
  endsequence

  a_addr_latch_hold: assert property (
    s_host_write(cpu_port_pkg::KIND_ADDR) |=> lat_stb && lat_addr == $past(sy.ad)
  ) else $error("address latch did not capture the host byte");

  a_kind_tag_kept: assert property (
    ce && sy.wr_pulse |=> lat_kind == $past(sy.kind)
  ) else $error("latched kind differs from the control pins");

  a_ctrl_reg_write: assert property (
    s_host_write(cpu_port_pkg::KIND_CTRL) |=> !lat_stb &&
      {mode_playback, dst_card, src_parallel} == $past(sy.ad[2:0])
  ) else $error("control register write not applied");

  a_read_drives_port: assert property (
    ce && sy.rd && sy.kind != cpu_port_pkg::KIND_CTRL |=>
      host_ad_oe && host_ad_out == $past(q.out_reg)
  ) else $error("output register not driven during host read");

  a_port_released: assert property (
    ce && !sy.rd |=> !host_ad_oe
  ) else $error("port still driven without a host read");

  a_download_route: assert property (
    s_download_par |=> mem_wdata == $past(par_data) &&
      flash_wr == !$past(dst_card) && card_wr == $past(dst_card)
  ) else $error("parallel data not routed to the selected memory");

  a_playback_to_host: assert property (
    ce && mode_playback && dst_card && card_rd_valid |=>
      q.out_reg == $past(card_rd_data)
  ) else $error("card read data did not reach the host register");

  a_playback_no_write: assert property (
    ce && mode_playback |=> !flash_wr && !card_wr
  ) else $error("memory written while in playback mode");

  // Host data bytes reach memory only in download mode with the host as source.
  sequence s_host_data_path;
    ce && !q.ctrl[`CTL_PLAYBACK_BIT] && !q.ctrl[`CTL_SRC_PAR_BIT] &&
      sy.wr_pulse && sy.kind == cpu_port_pkg::KIND_DATA;
  endsequence

  a_host_data_route: assert property (
    s_host_data_path |=> mem_wdata == $past(sy.ad) &&
      flash_wr == !$past(dst_card) && card_wr == $past(dst_card)
  ) else $error("host data byte not routed to the selected memory");

  a_ctrl_read_back: assert property (
    ce && sy.rd && sy.kind == cpu_port_pkg::KIND_CTRL |=>
      host_ad_oe && host_ad_out == $past(q.ctrl)
  ) else $error("control register not returned on a control read");

  a_flash_to_out: assert property (
    ce && mode_playback && !dst_card && flash_rd_valid |=>
      q.out_reg == $past(flash_rd_data)
  ) else $error("flash read data did not reach the host register");

  a_out_reg_hold: assert property (
    ce && !mode_playback |=> q.out_reg == $past(q.out_reg)
  ) else $error("output register loaded outside playback mode");

  // The synchroniser freezes with the rest, so a host strobe that begins and
  // ends while the enable is low is lost rather than replayed later.
  a_freeze_state: assert property (
    !ce |=> $stable(q)
  ) else $error("port state changed while the clock enable was low");

  a_wr_pulse_once: assert property (
    ce && sy.wr_pulse |=> !sy.wr_pulse
  ) else $error("host write strobe counted more than once");

  a_no_stray_strobe: assert property (
    ce && !sy.wr_pulse |=> !lat_stb
  ) else $error("latch strobe without a host write");

endmodule : cpu_host_port_data_mux

// *** cpu_port_defs.svh ***
// Constants for the host port and data path selector.
`ifndef CPU_PORT_DEFS_SVH
`define CPU_PORT_DEFS_SVH

// Bit positions inside the device control register.
`define CTL_SRC_PAR_BIT 0
`define CTL_DST_CARD_BIT 1
`define CTL_PLAYBACK_BIT 2

// Control register after reset: host source, internal flash, download mode.
`define CTL_RESET 8'h00

// Host pin vector layout after the pin synchroniser.
`define PIN_AD_LSB 0
`define PIN_AD_MSB 7
`define PIN_WR_BIT 8
`define PIN_RD_BIT 9
`define PIN_KIND_LSB 10
`define PIN_KIND_MSB 11
`define PIN_RESET 12'h000

`define BYTE_RESET 8'h00

`endif

// *** cpu_port_pkg.sv ***
// Types shared by the host port modules.
package cpu_port_pkg;

  // Meaning of a host transfer, given on the control port kind pins.
  typedef enum logic [1:0] {
    KIND_ADDR = 2'b00,
    KIND_DATA = 2'b01,
    KIND_CMD = 2'b10,
    KIND_CTRL = 2'b11
  } port_kind_t;

  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] s3;
    logic [11:0] stable;
    logic wr_pulse;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] lat_addr;
    logic [7:0] lat_data;
    logic [7:0] lat_cmd;
    port_kind_t lat_kind;
    logic lat_stb;
    logic [7:0] ctrl;
    logic [7:0] out_reg;
    logic [7:0] ad_out;
    logic ad_oe;
    logic [7:0] mem_wdata;
    logic flash_wr;
    logic card_wr;
  } port_state_t;

endpackage : cpu_port_pkg

// *** host_gpio_model.sv ***
// Behavioural host microcontroller that works the device's GPIO port.
`timescale 1ns/1ps
module host_gpio_model (
  input wire logic clk,
  input wire logic [7:0] ad_from_dev,
  input wire logic dev_oe,
  output logic [7:0] ad_pins,
  output logic wr_stb,
  output logic rd,
  output logic [1:0] kind
);
  logic [7:0] drv;
  logic drv_en;
  // The pins have no pull, so a released bus shows the inverse byte, not a stale copy.
  assign ad_pins = dev_oe ? ad_from_dev : (drv_en ? drv : ~drv);
  initial begin
    drv = 8'h00;
    drv_en = 1'b1;
    wr_stb = 1'b0;
    rd = 1'b0;
    kind = 2'h0;
  end
  task automatic host_write(input logic [1:0] k, input logic [7:0] b);
    @(posedge clk);
    #1;
    drv = b;
    kind = k;
    drv_en = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    wr_stb = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    wr_stb = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : host_write
  task automatic host_read(input logic [1:0] k, output logic [7:0] b, output logic ok);
    int i;
    @(posedge clk);
    #1;
    drv_en = 1'b0;
    kind = k;
    ok = 1'b0;
    b = 8'hxx;
    repeat (4) @(posedge clk);
    #1;
    rd = 1'b1;
    for (i = 0; i < 10 && !ok; i++) begin
      @(posedge clk);
      #1;
      ok = (dev_oe === 1'b1);
    end
    b = ad_from_dev;
    rd = 1'b0;
    for (i = 0; i < 10 && dev_oe !== 1'b0; i++) @(posedge clk);
    ok = ok && (dev_oe === 1'b0);
    #1;
    drv_en = 1'b1;
  endtask : host_read
endmodule : host_gpio_model

// *** host_pin_sync.sv ***
// Three-stage synchroniser and write strobe detector for the host GPIO pins.
`timescale 1ns/1ps
`include "cpu_port_defs.svh"
module host_pin_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [11:0] pins,
  host_sync_if.src sy
);

  cpu_port_pkg::sync_state_t q;
  cpu_port_pkg::sync_state_t d;
  logic [11:0] differ;

  always_comb begin
    d = q;
    differ = q.s2 ^ q.s3;
    if (ce) begin
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // A bit only moves once the second and third stages agree, so a pin
      // caught mid-transition cannot glitch the value seen by the port logic.
      d.stable = (~differ & q.s3) | (differ & q.stable);
      d.wr_pulse = d.stable[`PIN_WR_BIT] & ~q.stable[`PIN_WR_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{s1: `PIN_RESET, s2: `PIN_RESET, s3: `PIN_RESET, stable: `PIN_RESET,
             wr_pulse: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign sy.ad = q.stable[`PIN_AD_MSB:`PIN_AD_LSB];
  assign sy.kind = cpu_port_pkg::port_kind_t'(q.stable[`PIN_KIND_MSB:`PIN_KIND_LSB]);
  assign sy.rd = q.stable[`PIN_RD_BIT];
  assign sy.wr_pulse = q.wr_pulse;

endmodule : host_pin_sync

// *** host_sync_if.sv ***
// Carrier for the synchronised host pins between the synchroniser and the port logic.
`timescale 1ns/1ps
interface host_sync_if;
  logic [7:0] ad;
  cpu_port_pkg::port_kind_t kind;
  logic rd;
  logic wr_pulse;

  modport src (output ad, output kind, output rd, output wr_pulse);
  modport dst (input ad, input kind, input rd, input wr_pulse);
endinterface : host_sync_if

// *** tb.sv ***
// Self-checking bench for the host port and data path selector.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] ad_pins, host_ad_out, par_data, flash_rd_data, card_rd_data;
  logic [7:0] lat_addr, lat_data, lat_cmd, mem_wdata;
  logic [1:0] kind, lat_kind;
  logic wr_stb, rd, host_ad_oe, lat_stb, flash_wr, card_wr, src_parallel, dst_card;
  logic mode_playback, par_valid, flash_rd_valid, card_rd_valid;
  int n_mismatch = 0;
  int check_count = 0;
  int n_stb = 0;
  int n_fwr = 0;
  int n_cwr = 0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (lat_stb === 1'b1) n_stb++;
    if (flash_wr === 1'b1) n_fwr++;
    if (card_wr === 1'b1) n_cwr++;
  end
  host_gpio_model host (.clk(clk), .ad_from_dev(host_ad_out), .dev_oe(host_ad_oe),
    .ad_pins(ad_pins), .wr_stb(wr_stb), .rd(rd), .kind(kind));
  cpu_host_port_data_mux DUT (.clk(clk), .arst_n(arst_n), .ce(ce), .host_ad_in(ad_pins),
    .host_wr_stb(wr_stb), .host_rd(rd), .host_kind(kind), .host_ad_out(host_ad_out),
    .host_ad_oe(host_ad_oe), .par_data(par_data), .par_valid(par_valid),
    .flash_rd_data(flash_rd_data), .flash_rd_valid(flash_rd_valid),
    .card_rd_data(card_rd_data), .card_rd_valid(card_rd_valid), .lat_addr(lat_addr),
    .lat_data(lat_data), .lat_cmd(lat_cmd), .lat_kind(lat_kind), .lat_stb(lat_stb),
    .mem_wdata(mem_wdata), .flash_wr(flash_wr), .card_wr(card_wr),
    .src_parallel(src_parallel), .dst_card(dst_card), .mode_playback(mode_playback));
  task automatic wrap_up();
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [1:0] k, input logic [7:0] exp, input string what);
    logic [7:0] b;
    logic ok;
    host.host_read(k, b, ok);
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: read handshake timed out", $time);
      wrap_up();
    end
    check(b, exp, what);
  endtask : rd_chk
  task automatic par_two(input logic [7:0] a, input logic [7:0] b, input logic [7:0] w);
    @(posedge clk);
    #1;
    par_valid = 1'b1;
    par_data = a;
    @(posedge clk);
    #1;
    par_data = b;
    @(posedge clk);
    #1;
    par_valid = 1'b0;
    check(mem_wdata, w, "parallel byte");
    repeat (2) @(posedge clk);
  endtask : par_two
  // Both memories answer at once; only the selected one may reach the host.
  task automatic mem_push(input logic sel_card, input logic [7:0] b);
    @(posedge clk);
    #1;
    flash_rd_valid = 1'b1;
    card_rd_valid = 1'b1;
    flash_rd_data = sel_card ? ~b : b;
    card_rd_data = sel_card ? b : ~b;
    @(posedge clk);
    #1;
    flash_rd_valid = 1'b0;
    card_rd_valid = 1'b0;
  endtask : mem_push
  task automatic sc_reset();
    check({5'h00, mode_playback, dst_card, src_parallel}, 8'h00, "ctrl reset");
    check({7'h00, host_ad_oe}, 8'h00, "idle oe");
    rd_chk(2'h3, 8'h00, "ctrl read");
  endtask : sc_reset
  task automatic sc_latch();
    host.host_write(2'h0, 8'h5A);
    host.host_write(2'h0, 8'hA5);
    host.host_write(2'h2, 8'h3C);
    host.host_write(2'h1, 8'hC3);
    check(lat_addr, 8'hA5, "addr latch");
    check(lat_cmd, 8'h3C, "cmd latch");
    check(lat_data, 8'hC3, "data latch");
    check({6'h00, lat_kind}, 8'h01, "kind");
    check(8'(n_stb), 8'h04, "strobes");
    check(8'(n_fwr), 8'h01, "host to flash");
    check(mem_wdata, 8'hC3, "host byte");
  endtask : sc_latch
  // A whole host write inside a low clock enable must leave every latch untouched.
  task automatic sc_freeze();
    @(posedge clk);
    #1;
    ce = 1'b0;
    host.host_write(2'h0, 8'h42);
    ce = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(lat_addr, 8'hA5, "frozen latch");
    check(8'(n_stb), 8'h04, "no strobe while frozen");
  endtask : sc_freeze
  task automatic sc_download();
    host.host_write(2'h3, 8'h01);
    par_two(8'hE1, 8'hE2, 8'hE2);
    check(8'(n_fwr), 8'h03, "flash writes");
    host.host_write(2'h3, 8'h03);
    par_two(8'hD1, 8'hD2, 8'hD2);
    check(8'(n_cwr), 8'h02, "card writes");
    host.host_write(2'h3, 8'h05);
    par_two(8'h11, 8'h22, 8'hD2);
    check(8'(n_cwr + n_fwr), 8'h05, "playback ignores port");
  endtask : sc_download
  task automatic sc_playback();
    host.host_write(2'h3, 8'h06);
    check({5'h00, mode_playback, dst_card, src_parallel}, 8'h06, "ctrl bits");
    mem_push(1'b1, 8'h77);
    rd_chk(2'h0, 8'h77, "card to host");
    host.host_write(2'h3, 8'h04);
    mem_push(1'b0, 8'h99);
    rd_chk(2'h0, 8'h99, "flash to host");
    rd_chk(2'h3, 8'h04, "ctrl readback");
    check(8'(n_stb), 8'h04, "no strobe on ctrl");
  endtask : sc_playback
  // Reset in mid-run from playback must bring back the host-to-flash path.
  task automatic sc_rerst();
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({5'h00, mode_playback, dst_card, src_parallel}, 8'h00, "ctrl in reset");
    check(lat_addr, 8'h00, "latch in reset");
    arst_n = 1'b1;
    host.host_write(2'h1, 8'h6E);
    check(mem_wdata, 8'h6E, "host byte after reset");
    check(8'(n_fwr), 8'h04, "flash write after reset");
    check(8'(n_cwr), 8'h02, "no card write after reset");
  endtask : sc_rerst
  initial begin
    par_data = 8'h00;
    par_valid = 1'b0;
    flash_rd_data = 8'h00;
    flash_rd_valid = 1'b0;
    card_rd_data = 8'h00;
    card_rd_valid = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    sc_reset();
    sc_latch();
    sc_freeze();
    sc_download();
    sc_playback();
    sc_rerst();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("wrong value at %0t: run timed out", $time);
    wrap_up();
  end
endmodule : tb
